// ===== hdl/timer_pkg.sv
// Purpose: Shared constants and types for the dual byte timer with PWM outputs
// Assumes: Register indices are word indices on APB; byte address is four times the index
// Notes: Channel 0 is the low byte, channel 1 the high byte
package timer_pkg;
    // Printed register indices and their APB byte addresses
    localparam logic [15:0] CTRL_IDX = 16'hFE18;
    localparam logic [15:0] PRESCALE_IDX = 16'hFE19;
    localparam logic [15:0] LOW_COUNT_IDX = 16'hFE1A;
    localparam logic [15:0] HIGH_COUNT_IDX = 16'hFE1B;
    localparam logic [15:0] LOW_RELOAD_IDX = 16'hFE1C;
    localparam logic [15:0] HIGH_RELOAD_IDX = 16'hFE1D;
    localparam int ADDR_W = 18;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] PRESCALE_ADDR = {PRESCALE_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] LOW_COUNT_ADDR = {LOW_COUNT_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] HIGH_COUNT_ADDR = {HIGH_COUNT_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] LOW_RELOAD_ADDR = {LOW_RELOAD_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] HIGH_RELOAD_ADDR = {HIGH_RELOAD_IDX, 2'b00};

    // Reset values, counter limits and prescale divider constants
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] PRESCALE_RESET = 8'h00;
    localparam logic [7:0] RELOAD_RESET = 8'h00;
    localparam logic [7:0] COUNT_ZERO = 8'h00;
    localparam logic [7:0] COUNT_TOP = 8'hFF;
    localparam logic [7:0] DIV_MASK_FULL = 8'hFF;
    localparam logic [2:0] DIV_CODE_MAX = 3'h7;

    // Field layout of timer_control, bit 7 down to bit 0
    typedef struct packed {
        logic high_run;
        logic low_run;
        logic length_select;
        logic output_mode_select;
        logic high_match_flag;
        logic high_irq_enable;
        logic low_match_flag;
        logic low_irq_enable;
    } timer_control_t;

    // Field layout of prescale_config, bit 7 down to bit 0
    typedef struct packed {
        logic high_prescale_enable;
        logic [2:0] high_prescale_code;
        logic low_prescale_enable;
        logic [2:0] low_prescale_code;
    } prescale_config_t;

    // Prescale setting of one byte: enable then code
    typedef struct packed {
        logic enable;
        logic [2:0] code;
    } div_setting_t;

    // Operating mode is {length_select, output_mode_select}
    typedef enum logic [1:0] {
        MODE_SPLIT_TOGGLE = 2'b00,
        MODE_SPLIT_PWM = 2'b01,
        MODE_LONG_TOGGLE = 2'b10,
        MODE_LONG_MIXED = 2'b11
    } timer_mode_t;
endpackage

// ===== hdl/dual_byte_timer_pwm.sv
// Purpose: Two 8-bit up-counters with prescalers, match buffers, toggle/PWM outputs
// Assumes: APB slave with zero wait states; event input arrives from a pin
// Notes: Index 0 of each per-byte array is the low byte, index 1 the high byte
// Behaviour
// [R01] High byte stopped: count zero, buffer follows reload
// [R02] Low byte stopped: count zero, buffer follows reload
// [R03] Length bit chains high byte onto low
// [R04] Each byte has its own match signal
// [R05] Mode bits pick toggle or PWM outputs
// [R06] PWM period is 256 prescaled counts
// [R07] Toggle output inverts on every match
// [R08] Mode 3 high byte counts low PWM periods
// [R09] High flag set at zero, software clears
// [R10] Low flag set at zero, software clears
// [R11] High enable and flag raise interrupt
// [R12] Low enable and flag raise interrupt
// [R13] Prescale change waits for buffer reload
// [R14] High prescale divides by 1 or 2..256
// [R15] Low prescale divides by 1 or 2..256
// [R16] Counters read-only, step per prescaler pulse
// [R17] Running low buffer reloads only when count reaches zero
// [R18] Running high buffer reloads only when count reaches zero
// [R19] Low match compares against buffer, not register
// [R20] Counters clear on match per mode
// [R21] PWM clears on overflow, sets on match
// [R22] Output high when stopped, low at FFH
// [R23] Prescaler input clock chosen by mode
// [R24] Writes land at access edge, reads passive
`timescale 1ns/1ns
module dual_byte_timer_pwm (
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic EVENT_IN,
    input wire logic EVENT_SELECT,
    output logic HIGH_WAVE_OUT,
    output logic LOW_WAVE_OUT,
    output logic TIMER_IRQ
);
    import timer_pkg::*;

    timer_control_t ctrl;
    prescale_config_t prescale;
    logic [7:0] reload [2];
    logic [7:0] cnt [2];
    logic [7:0] mbuf [2];
    logic [7:0] pre_cnt [2];
    div_setting_t div_sel [2];
    logic [1:0] wave;
    logic [31:0] rdata_hold;
    logic half_phase;
    logic event_meta;
    logic event_sync;
    logic event_last;

    // Per-byte control and event wires
    logic [1:0] run;
    logic [1:0] src_tick;
    logic [1:0] pre_tick;
    logic [1:0] cnt_tick;
    logic [1:0] is_match;
    logic [1:0] clr_on_match;
    logic [1:0] pwm_mode;
    logic [1:0] match_ev;
    logic [1:0] ovf_ev;
    logic [1:0] reach0;
    logic [7:0] next_cnt [2];
    logic [7:0] div_last [2];
    div_setting_t div_req [2];

    // APB decode
    wire in_range = (PADDR[31:ADDR_W] == '0);
    wire [ADDR_W-1:0] addr = PADDR[ADDR_W-1:0];
    wire hit_ctrl = in_range && (addr == CTRL_ADDR);
    wire hit_pre = in_range && (addr == PRESCALE_ADDR);
    wire hit_lcnt = in_range && (addr == LOW_COUNT_ADDR);
    wire hit_hcnt = in_range && (addr == HIGH_COUNT_ADDR);
    wire hit_lrel = in_range && (addr == LOW_RELOAD_ADDR);
    wire hit_hrel = in_range && (addr == HIGH_RELOAD_ADDR);
    wire mapped = hit_ctrl | hit_pre | hit_lcnt | hit_hcnt | hit_lrel | hit_hrel;
    wire setup_phase = PSEL && !PENABLE;
    wire access_phase = PSEL && PENABLE;
    wire wr_en = access_phase && PWRITE && mapped;
    wire [7:0] wbyte = PWDATA[7:0];
    wire [7:0] rd_byte = hit_ctrl ? ctrl :
                         hit_pre ? prescale :
                         hit_lcnt ? cnt[0] :
                         hit_hcnt ? cnt[1] :
                         hit_lrel ? reload[0] :
                         hit_hrel ? reload[1] : 8'h00;

    assign PREADY = 1'b1;
    assign PSLVERR = access_phase && !mapped;
    assign PRDATA = rdata_hold;

    // Read data is captured in setup so the access phase shows a flop output
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rdata_hold <= 32'h0000_0000;
        end else if (setup_phase) begin
            rdata_hold <= {24'h00_0000, rd_byte}; // R24
        end
    end

    // Free-running half rate enable for the 2 Tcyc count clock
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            half_phase <= 1'b0;
        end else begin
            half_phase <= !half_phase;
        end
    end

    // Event pin synchroniser; the edge detector reads only the second stage onward
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            event_meta <= 1'b0;
            event_sync <= 1'b0;
            event_last <= 1'b0;
        end else begin
            event_meta <= EVENT_IN;
            event_sync <= event_meta;
            event_last <= event_sync;
        end
    end

    wire event_edge = event_sync && !event_last;
    wire tick2 = half_phase;
    timer_mode_t mode;
    assign mode = timer_mode_t'({ctrl.length_select, ctrl.output_mode_select});

    assign run = {ctrl.high_run, ctrl.low_run};
    assign div_req[0] = '{prescale.low_prescale_enable, prescale.low_prescale_code};
    assign div_req[1] = '{prescale.high_prescale_enable, prescale.high_prescale_code};

    // Low prescaler input: 2 Tcyc or events in toggle modes, every cycle in PWM modes
    assign src_tick[0] = ctrl.output_mode_select ? 1'b1 :
                         (EVENT_SELECT ? event_edge : tick2); // R23
    // High prescaler input follows the mode; modes 2 and 3 chain onto the low byte
    assign src_tick[1] = (mode == MODE_SPLIT_TOGGLE) ? tick2 :
                         (mode == MODE_SPLIT_PWM) ? 1'b1 :
                         (mode == MODE_LONG_TOGGLE) ? match_ev[0] : ovf_ev[0]; // R03 R08 R23

    // Low clears on match in modes 0 and 2, high in modes 0, 2 and 3
    assign clr_on_match[0] = !ctrl.output_mode_select; // R20
    assign clr_on_match[1] = (mode != MODE_SPLIT_PWM); // R20
    // Only the mode 1 high byte and the mode 1/3 low byte are PWM outputs
    assign pwm_mode[0] = ctrl.output_mode_select; // R05
    assign pwm_mode[1] = (mode == MODE_SPLIT_PWM); // R05

    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_byte
            // Terminal prescaler count: 0 for divide by 1, 2**(code+1)-1 otherwise
            assign div_last[c] = div_sel[c].enable ?
                (DIV_MASK_FULL >> (DIV_CODE_MAX - div_sel[c].code)) : COUNT_ZERO; // R14 R15
            assign pre_tick[c] = run[c] && src_tick[c] && (pre_cnt[c] == div_last[c]);
            assign cnt_tick[c] = pre_tick[c];
            // Compare is against the buffer so a reload write cannot cut a period short
            assign is_match[c] = (cnt[c] == mbuf[c]); // R04 R19
            assign next_cnt[c] = (is_match[c] && clr_on_match[c]) ? COUNT_ZERO :
                                 8'(cnt[c] + 8'h01); // R16 R20
            assign match_ev[c] = cnt_tick[c] && is_match[c]; // R04
            assign ovf_ev[c] = cnt_tick[c] && (cnt[c] == COUNT_TOP) &&
                               !(is_match[c] && clr_on_match[c]);
            assign reach0[c] = cnt_tick[c] && (next_cnt[c] == COUNT_ZERO);

            always_ff @(posedge CLK or posedge RST) begin
                if (RST) begin
                    pre_cnt[c] <= COUNT_ZERO;
                end else if (!run[c]) begin
                    pre_cnt[c] <= COUNT_ZERO;
                end else if (src_tick[c]) begin
                    pre_cnt[c] <= pre_tick[c] ? COUNT_ZERO : 8'(pre_cnt[c] + 8'h01);
                end
            end

            always_ff @(posedge CLK or posedge RST) begin
                if (RST) begin
                    cnt[c] <= COUNT_ZERO;
                end else if (!run[c]) begin
                    cnt[c] <= COUNT_ZERO; // R01 R02
                end else if (cnt_tick[c]) begin
                    cnt[c] <= next_cnt[c]; // R16
                end
            end

            // Buffer and active prescale setting change together, only at zero while running
            always_ff @(posedge CLK or posedge RST) begin
                if (RST) begin
                    mbuf[c] <= RELOAD_RESET;
                    div_sel[c] <= '0;
                end else if (!run[c] || reach0[c]) begin
                    mbuf[c] <= reload[c]; // R01 R02 R17 R18
                    div_sel[c] <= div_req[c]; // R13
                end
            end

            always_ff @(posedge CLK or posedge RST) begin
                if (RST) begin
                    wave[c] <= 1'b1;
                end else if (!run[c]) begin
                    wave[c] <= 1'b1; // R22
                end else if (reload[c] == COUNT_TOP) begin
                    wave[c] <= 1'b0; // R22
                end else if (pwm_mode[c]) begin
                    if (ovf_ev[c]) begin
                        wave[c] <= 1'b0; // R06 R21
                    end else if (match_ev[c]) begin
                        wave[c] <= 1'b1; // R21
                    end
                end else if (match_ev[c]) begin
                    wave[c] <= !wave[c]; // R07
                end
            end
        end
    endgenerate

    // Register writes; a hardware flag set in the same cycle beats a software clear
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctrl <= timer_control_t'(CTRL_RESET);
            prescale <= prescale_config_t'(PRESCALE_RESET);
            reload[0] <= RELOAD_RESET;
            reload[1] <= RELOAD_RESET;
        end else begin
            if (wr_en && hit_ctrl) begin
                ctrl <= timer_control_t'(wbyte); // R24
            end
            if (wr_en && hit_pre) begin
                prescale <= prescale_config_t'(wbyte); // R24
            end
            if (wr_en && hit_lrel) begin
                reload[0] <= wbyte; // R24
            end
            if (wr_en && hit_hrel) begin
                reload[1] <= wbyte; // R24
            end
            if (reach0[1]) begin
                ctrl.high_match_flag <= 1'b1; // R09
            end
            if (reach0[0]) begin
                ctrl.low_match_flag <= 1'b1; // R10
            end
        end
    end

    assign TIMER_IRQ = (ctrl.high_irq_enable && ctrl.high_match_flag) || // R11
                       (ctrl.low_irq_enable && ctrl.low_match_flag); // R12
    assign HIGH_WAVE_OUT = wave[1];
    assign LOW_WAVE_OUT = wave[0];

    // Checks
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    sequence low_toggle_match_s;
        ctrl.low_run && !ctrl.output_mode_select && (reload[0] != 8'hFF) && match_ev[0];
    endsequence

    sequence low_pwm_overflow_s;
        ctrl.low_run && ctrl.output_mode_select && (reload[0] != 8'hFF) && ovf_ev[0];
    endsequence

    // A zero buffer pins the count at zero, so no step can be seen there
    sequence high_chain_tick_s;
        ctrl.high_run && (mode == MODE_LONG_TOGGLE) && (pre_cnt[1] == div_last[1]) &&
            (mbuf[1] != 8'h00) && match_ev[0];
    endsequence

    high_stop_hold_a: assert property ( // R01
        !ctrl.high_run |=> (cnt[1] == 8'h00) && (mbuf[1] == $past(reload[1])))
        else $error("high byte not held while stopped");

    low_stop_hold_a: assert property ( // R02
        !ctrl.low_run |=> (cnt[0] == 8'h00) && (mbuf[0] == $past(reload[0])))
        else $error("low byte not held while stopped");

    high_chain_step_a: assert property ( // R03
        high_chain_tick_s |=> cnt[1] != $past(cnt[1]))
        else $error("high byte did not step on low match");

    low_toggle_flip_a: assert property ( // R07
        low_toggle_match_s |=> LOW_WAVE_OUT != $past(LOW_WAVE_OUT))
        else $error("low toggle output did not invert on match");

    high_flag_set_a: assert property ( // R09
        reach0[1] |=> ctrl.high_match_flag)
        else $error("high match flag not set at zero");

    low_flag_set_a: assert property ( // R10
        reach0[0] |=> ctrl.low_match_flag ##1 ctrl.low_match_flag || $past(wr_en && hit_ctrl))
        else $error("low match flag not set or lost");

    high_irq_req_a: assert property ( // R11
        (ctrl.high_irq_enable && ctrl.high_match_flag) |-> TIMER_IRQ)
        else $error("high interrupt request missing");

    low_irq_req_a: assert property ( // R12
        (ctrl.low_irq_enable && ctrl.low_match_flag) |-> TIMER_IRQ)
        else $error("low interrupt request missing");

    low_div_hold_a: assert property ( // R13
        (ctrl.low_run && !reach0[0]) |=> div_sel[0] == $past(div_sel[0]))
        else $error("low prescale changed outside a reload");

    low_buf_hold_a: assert property ( // R17
        (ctrl.low_run && !reach0[0]) |=> mbuf[0] == $past(mbuf[0]))
        else $error("low match buffer changed outside a reload");

    low_pwm_clear_a: assert property ( // R21
        low_pwm_overflow_s |=> !LOW_WAVE_OUT)
        else $error("low PWM output not cleared on overflow");

    low_stop_high_a: assert property ( // R22
        !ctrl.low_run |=> LOW_WAVE_OUT [*1])
        else $error("low output not high while stopped");

    high_toggle_flip_a: assert property ( // R07
        ctrl.high_run && (mode != MODE_SPLIT_PWM) && (reload[1] != 8'hFF) && match_ev[1]
            |=> HIGH_WAVE_OUT != $past(HIGH_WAVE_OUT))
        else $error("high toggle output did not invert on match");

    low_count_step_a: assert property ( // R16
        (ctrl.low_run && cnt_tick[0] && (cnt[0] != mbuf[0]))
            |=> cnt[0] == 8'($past(cnt[0]) + 8'h01))
        else $error("low counter did not step by one");

    low_count_idle_a: assert property ( // R16
        (ctrl.low_run && !cnt_tick[0]) |=> $stable(cnt[0]))
        else $error("low counter moved without a prescaler pulse");

    high_buf_hold_a: assert property ( // R18
        (ctrl.high_run && !reach0[1]) |=> mbuf[1] == $past(mbuf[1]))
        else $error("high match buffer changed outside a reload");

    low_match_clear_a: assert property ( // R20
        (ctrl.low_run && !ctrl.output_mode_select && match_ev[0]) |=> cnt[0] == 8'h00)
        else $error("low counter not cleared on match");

    low_full_low_a: assert property ( // R22
        (ctrl.low_run && (reload[0] == 8'hFF)) |=> !LOW_WAVE_OUT)
        else $error("low output not held low at full reload");

    high_stop_high_a: assert property ( // R22
        !ctrl.high_run |=> HIGH_WAVE_OUT)
        else $error("high output not high while stopped");

    reload_write_a: assert property ( // R24
        (wr_en && hit_lrel) |=> reload[0] == $past(wbyte))
        else $error("low reload write did not land");
endmodule

// ===== testbench/test_dual_byte_timer_pwm.sv
// Purpose: Self-checking bench for the dual byte timer over APB
// Assumes: Zero wait-state slave; wave periods measured rising edge to rising edge
// Notes: Every scenario stops both bytes before it returns
`timescale 1ns/1ns
module test_dual_byte_timer_pwm;
    import timer_pkg::*;
    localparam logic [31:0] A_CTRL = {14'h0, CTRL_ADDR};
    localparam logic [31:0] A_PRE = {14'h0, PRESCALE_ADDR};
    localparam logic [31:0] A_LCNT = {14'h0, LOW_COUNT_ADDR};
    localparam logic [31:0] A_HCNT = {14'h0, HIGH_COUNT_ADDR};
    localparam logic [31:0] A_LREL = {14'h0, LOW_RELOAD_ADDR};
    localparam logic [31:0] A_HREL = {14'h0, HIGH_RELOAD_ADDR};
    logic CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [31:0] PADDR = '0, PWDATA = '0, PRDATA;
    logic PREADY, PSLVERR, EVENT_IN = 0, EVENT_SELECT = 0;
    logic HIGH_WAVE_OUT, LOW_WAVE_OUT, TIMER_IRQ;
    logic ev_on = 0;
    logic [2:0] ev_cnt = '0;
    logic [31:0] rd;
    logic er;
    int errors = 0, checks_done = 0, per;
    dual_byte_timer_pwm dut_u (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .EVENT_IN(EVENT_IN), .EVENT_SELECT(EVENT_SELECT),
        .HIGH_WAVE_OUT(HIGH_WAVE_OUT), .LOW_WAVE_OUT(LOW_WAVE_OUT), .TIMER_IRQ(TIMER_IRQ));
    initial begin
        forever #5 CLK = ~CLK;
    end
    // External events every 5 cycles, one rising edge per 10 cycles
    always @(posedge CLK) begin
        if (ev_on) begin
            ev_cnt <= (ev_cnt == 3'h4) ? 3'h0 : ev_cnt + 3'h1;
            if (ev_cnt == 3'h4) EVENT_IN <= ~EVENT_IN;
        end
    end
    task automatic end_of_test();
        $display("checks %0d, errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: register %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: level %b, wanted %b", $time, got, exp);
        end
    endtask
    task automatic check_per(input int got, input int exp);
        checks_done++;
        if (got != exp) begin
            errors++;
            $display("unexpected at %0t: period %0d, wanted %0d", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [31:0] a, input logic [7:0] d);
        @(posedge CLK);
        PSEL <= 1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= {24'h0, d};
        @(posedge CLK);
        PENABLE <= 1;
        do begin
            @(posedge CLK);
        end while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 0;
        PENABLE <= 0;
        #1;
    endtask
    // Cycles between the second and third rising edge of the chosen wave
    task automatic measure(input bit hi, output int p);
        logic prev, cur;
        int n, edges, start;
        p = -1;
        n = 0;
        edges = 0;
        start = 0;
        prev = hi ? HIGH_WAVE_OUT : LOW_WAVE_OUT;
        while (edges < 3 && n < 5000) begin
            @(posedge CLK);
            #1;
            n++;
            cur = hi ? HIGH_WAVE_OUT : LOW_WAVE_OUT;
            if (cur === 1'b1 && prev === 1'b0) begin
                edges++;
                if (edges == 2) start = n;
                if (edges == 3) p = n - start;
            end
            prev = cur;
        end
    endtask
    task automatic t_registers();
        logic [31:0] addrs [6];
        addrs = '{A_CTRL, A_PRE, A_LCNT, A_HCNT, A_LREL, A_HREL};
        foreach (addrs[i]) begin
            apb(0, addrs[i], 8'h00);
            check_reg(rd, 32'h0);
        end
        apb(1, A_LREL, 8'hA5);
        apb(1, A_PRE, 8'h5A);
        apb(1, A_LCNT, 8'h33);
        apb(0, A_LREL, 8'h00);
        check_reg(rd, 32'hA5);
        apb(0, A_PRE, 8'h00);
        check_reg(rd, 32'h5A);
        apb(0, A_LCNT, 8'h00);
        check_reg(rd, 32'h0);
        apb(0, 32'h0003F878, 8'h00);
        check_bit(er, 1'b1);
        check_reg(rd, 32'h0);
        apb(1, A_PRE, 8'h00);
    endtask
    task automatic t_low_toggle_irq();
        check_bit(LOW_WAVE_OUT, 1'b1);
        apb(1, A_LREL, 8'h01);
        apb(1, A_CTRL, 8'h41);
        measure(0, per);
        check_per(per, 8);
        apb(0, A_CTRL, 8'h00);
        check_reg(rd, 32'h43);
        check_bit(TIMER_IRQ, 1'b1);
        apb(1, A_CTRL, 8'h02);
        check_bit(TIMER_IRQ, 1'b0);
        apb(0, A_LCNT, 8'h00);
        check_reg(rd, 32'h0);
        check_bit(LOW_WAVE_OUT, 1'b1);
        apb(1, A_CTRL, 8'h00);
        apb(0, A_CTRL, 8'h00);
        check_reg(rd, 32'h0);
    endtask
    task automatic t_high_flag();
        apb(1, A_HREL, 8'h00);
        apb(1, A_CTRL, 8'h84);
        repeat (20) @(posedge CLK);
        apb(0, A_CTRL, 8'h00);
        check_reg(rd, 32'h8C);
        check_bit(TIMER_IRQ, 1'b1);
        apb(1, A_CTRL, 8'h0C);
        apb(1, A_CTRL, 8'h04);
        check_bit(TIMER_IRQ, 1'b0);
        apb(1, A_CTRL, 8'h00);
    endtask
    task automatic t_prescale(input bit hi);
        logic [7:0] pre;
        apb(1, A_LREL, 8'h00);
        apb(1, A_HREL, 8'h00);
        for (int i = 0; i < 9; i++) begin
            pre = (i == 0) ? 8'h00 : {5'b00001, 3'(i - 1)};
            apb(1, A_PRE, hi ? {pre[3:0], 4'h0} : pre);
            apb(1, A_CTRL, hi ? 8'h80 : 8'h40);
            measure(hi, per);
            check_per(per, 4 << i);
            apb(1, A_CTRL, 8'h00);
        end
        apb(1, A_PRE, 8'h00);
    endtask
    task automatic t_prescale_running();
        // Divide 256 taken at once would freeze the count near 0x01
        apb(1, A_LREL, 8'h40);
        apb(1, A_CTRL, 8'h40);
        apb(1, A_PRE, 8'h0F);
        repeat (40) @(posedge CLK);
        apb(0, A_LCNT, 8'h00);
        check_bit(rd[7:0] > 8'h10, 1'b1);
        apb(1, A_CTRL, 8'h00);
        apb(1, A_LREL, 8'h00);
        apb(1, A_PRE, 8'h00);
        apb(1, A_CTRL, 8'h40);
        apb(1, A_PRE, 8'h08);
        measure(0, per);
        check_per(per, 8);
        apb(1, A_CTRL, 8'h00);
        apb(1, A_PRE, 8'h00);
    endtask
    task automatic t_modes();
        apb(1, A_LREL, 8'h40);
        apb(1, A_HREL, 8'h40);
        apb(1, A_CTRL, 8'hD0);
        measure(0, per);
        check_per(per, 256);
        measure(1, per);
        check_per(per, 256);
        apb(1, A_CTRL, 8'h00);
        apb(1, A_HREL, 8'h00);
        apb(1, A_CTRL, 8'hF0);
        measure(1, per);
        check_per(per, 512);
        apb(1, A_CTRL, 8'h00);
        apb(1, A_LREL, 8'h01);
        apb(1, A_HREL, 8'h01);
        apb(1, A_CTRL, 8'hE0);
        measure(1, per);
        check_per(per, 16);
        measure(0, per);
        check_per(per, 8);
        apb(1, A_CTRL, 8'h00);
    endtask
    task automatic t_full_reload_and_events();
        apb(1, A_LREL, 8'hFF);
        apb(1, A_CTRL, 8'h40);
        repeat (30) @(posedge CLK);
        #1;
        check_bit(LOW_WAVE_OUT, 1'b0);
        apb(1, A_CTRL, 8'h00);
        apb(1, A_LREL, 8'h00);
        @(posedge CLK);
        EVENT_SELECT <= 1;
        ev_on <= 1;
        apb(1, A_CTRL, 8'h40);
        measure(0, per);
        check_per(per, 20);
        apb(1, A_CTRL, 8'h00);
    endtask
    initial begin
        repeat (4) @(posedge CLK);
        RST <= 0;
        t_registers();
        t_low_toggle_irq();
        t_high_flag();
        t_prescale(0);
        t_prescale(1);
        t_prescale_running();
        t_modes();
        t_full_reload_and_events();
        end_of_test();
    end
    initial begin
        repeat (60000) @(posedge CLK);
        errors++;
        end_of_test();
    end
endmodule
